// ---- rtl/bst_tap.sv ----
// Device end of the boundary-scan port: instruction, bypass, identity and boundary registers.
// Assumes the link test clock clocks it; resetn_i is the power-up reset.
// Overview of operation
// - Sample on rising, drive output on falling
// - Mode select pulled up when floating
// - Shift in at MSB, out at LSB
// - Power-up reset floats serial output
// - Five high mode-select edges reset controller
// - Port reset leaves memory untouched
// - Instruction selects exactly one scan register
// - Three-bit instruction register, serially loaded
// - Identity instruction after reset
// - Instruction capture loads 01 low bits
// - One-bit bypass cleared under bypass
// - Boundary register captures pins, shifts
// - Boundary register includes spare positions
// - Test and sample instructions capture pins
// - Identity register captures fixed 32-bit code
// - Reserved codes load, then select bypass
// - Instruction effective only after update
// - Unused port: clock low, output open
// - Outputs-floating instruction floats data bus
// - Cell 47 enables outputs under test
// - Bypass in path during data shift
`timescale 1ns/1ps
module bst_tap #(
    parameter int PIN_W = 40
) (
    // Link and power-up reset
    bst_if.dev link,
    input wire logic resetn_i,
    // Pin ring
    input wire logic [PIN_W-1:0] pins_i,
    input wire logic mem_q_oe_i,
    output logic [bst_pkg::BSR_W-1:0] preload_o,
    output logic extest_o,
    output logic q_oe_o
);
    bst_pkg::bst_state_t st;
    logic tms_eff;
    logic [bst_pkg::IR_W-1:0] ir_sh_ff;
    logic [bst_pkg::IR_W-1:0] ir_ff;
    logic byp_ff;
    logic [bst_pkg::ID_W-1:0] id_ff;
    logic [bst_pkg::BSR_W-1:0] bsr_ff;
    logic [bst_pkg::BSR_W-1:0] pre_ff;
    logic tdo_ff;
    logic oe_ff;
    logic nxt_tdo;
    logic use_bsr;
    logic [PIN_W-1:0] pins_s1_ff;
    logic [PIN_W-1:0] pins_s2_ff;
    logic qoe_s1_ff;
    logic qoe_s2_ff;

    assign tms_eff = (link.tms !== 1'b0);

    bst_fsm u_fsm (
        .tck_i(link.tck),
        .resetn_i(resetn_i),
        .tms_i(tms_eff),
        .state_o(st)
    );

    // Reserved codes fall back to bypass so a path always exists
    function automatic logic bst_is_bsr_op(input logic [bst_pkg::IR_W-1:0] op);
        case (op)
            bst_pkg::OP_EXTEST: bst_is_bsr_op = 1'b1;
            bst_pkg::OP_SAMPLE: bst_is_bsr_op = 1'b1;
            bst_pkg::OP_SAMPLE_Z: bst_is_bsr_op = 1'b1;
            default: bst_is_bsr_op = 1'b0;
        endcase
    endfunction

    assign use_bsr = bst_is_bsr_op(ir_ff);

    // Pin ring lives on the memory clock; two stages before capture.
    // Capture then sees pins a couple of test clocks old, traded for safety.
    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_s1_ff <= '0;
            pins_s2_ff <= '0;
            qoe_s1_ff <= 1'b0;
            qoe_s2_ff <= 1'b0;
        end else begin
            pins_s1_ff <= pins_i;
            pins_s2_ff <= pins_s1_ff;
            qoe_s1_ff <= mem_q_oe_i;
            qoe_s2_ff <= qoe_s1_ff;
        end
    end

    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_sh_ff <= bst_pkg::OP_IDREAD;
        end else if (st == bst_pkg::CAP_IR) begin
            ir_sh_ff <= {ir_sh_ff[bst_pkg::IR_W-1:2], bst_pkg::IR_CAPTURE_PAT};
        end else if (st == bst_pkg::SH_IR) begin
            ir_sh_ff <= {tms_dummy_tdi(link.tdi), ir_sh_ff[bst_pkg::IR_W-1:1]};
        end
    end

    function automatic logic tms_dummy_tdi(input logic v);
        tms_dummy_tdi = (v !== 1'b0);
    endfunction

    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_ff <= bst_pkg::OP_IDREAD;
        end else if (st == bst_pkg::TLR) begin
            ir_ff <= bst_pkg::OP_IDREAD;
        end else if (st == bst_pkg::UPD_IR) begin
            ir_ff <= ir_sh_ff;
        end
    end

    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            byp_ff <= 1'b0;
        end else if (st == bst_pkg::CAP_DR) begin
            byp_ff <= 1'b0;
        end else if (st == bst_pkg::SH_DR) begin
            byp_ff <= tms_dummy_tdi(link.tdi);
        end
    end

    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            id_ff <= bst_pkg::ID_VALUE;
        end else if (st == bst_pkg::CAP_DR && ir_ff == bst_pkg::OP_IDREAD) begin
            id_ff <= bst_pkg::ID_VALUE;
        end else if (st == bst_pkg::SH_DR && ir_ff == bst_pkg::OP_IDREAD) begin
            id_ff <= {tms_dummy_tdi(link.tdi), id_ff[bst_pkg::ID_W-1:1]};
        end
    end

    // Spare cells above the pin ring capture as zero; the enable cell captures the synchronised memory output enable
    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            bsr_ff <= '0;
        end else if (st == bst_pkg::CAP_DR && use_bsr) begin
            bsr_ff <= '0;
            bsr_ff[PIN_W-1:0] <= pins_s2_ff;
            bsr_ff[bst_pkg::OE_CELL] <= qoe_s2_ff;
        end else if (st == bst_pkg::SH_DR && use_bsr) begin
            bsr_ff <= {tms_dummy_tdi(link.tdi), bsr_ff[bst_pkg::BSR_W-1:1]};
        end
    end

    always_ff @(posedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_ff <= '0;
            pre_ff[bst_pkg::OE_CELL] <= 1'b1;
        end else if (st == bst_pkg::TLR) begin
            pre_ff[bst_pkg::OE_CELL] <= 1'b1;
        end else if (st == bst_pkg::UPD_DR && use_bsr) begin
            pre_ff <= bsr_ff;
        end
    end

    always_comb begin
        nxt_tdo = byp_ff;
        if (st == bst_pkg::SH_IR) begin
            nxt_tdo = ir_sh_ff[0];
        end else if (ir_ff == bst_pkg::OP_IDREAD) begin
            nxt_tdo = id_ff[0];
        end else if (use_bsr) begin
            nxt_tdo = bsr_ff[0];
        end
    end

    always_ff @(negedge link.tck or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            tdo_ff <= nxt_tdo;
            oe_ff <= (st == bst_pkg::SH_DR) || (st == bst_pkg::SH_IR);
        end
    end

    assign link.tdo = tdo_ff;
    assign link.tdo_oe = oe_ff;
    assign preload_o = pre_ff;
    // Test logic only gates bus drive; memory core never sees the port reset
    assign extest_o = (ir_ff == bst_pkg::OP_EXTEST);
    always_comb begin
        case (ir_ff)
            bst_pkg::OP_SAMPLE_Z: q_oe_o = 1'b0;
            bst_pkg::OP_EXTEST: q_oe_o = pre_ff[bst_pkg::OE_CELL];
            default: q_oe_o = mem_q_oe_i;
        endcase
    end
endmodule

// ---- common/bst_pkg.sv ----
// Package for the boundary-scan test port: opcodes, register widths, reset values.
// Assumes both ends are compiled against the same constants.
package bst_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 64;
    localparam int OE_CELL = 47;
    localparam int RESET_TMS_EDGES = 5;
    // Opcodes chosen freely; the other three codes are reserved
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDREAD = 3'h1;
    localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
    localparam logic [2:0] OP_SAMPLE = 3'h4;
    localparam logic [2:0] OP_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    // Identification value is arbitrary
    localparam logic [31:0] ID_VALUE = 32'h0a5c_3001;
    localparam int DIV_HALF = 2;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_state_t;
    function automatic bst_state_t bst_next(input bst_state_t s, input logic tms);
        case (s)
            TLR: bst_next = tms ? TLR : RTI;
            RTI: bst_next = tms ? SEL_DR : RTI;
            SEL_DR: bst_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: bst_next = tms ? EX1_DR : SH_DR;
            SH_DR: bst_next = tms ? EX1_DR : SH_DR;
            EX1_DR: bst_next = tms ? UPD_DR : PA_DR;
            PA_DR: bst_next = tms ? EX2_DR : PA_DR;
            EX2_DR: bst_next = tms ? UPD_DR : SH_DR;
            UPD_DR: bst_next = tms ? SEL_DR : RTI;
            SEL_IR: bst_next = tms ? TLR : CAP_IR;
            CAP_IR: bst_next = tms ? EX1_IR : SH_IR;
            SH_IR: bst_next = tms ? EX1_IR : SH_IR;
            EX1_IR: bst_next = tms ? UPD_IR : PA_IR;
            PA_IR: bst_next = tms ? EX2_IR : PA_IR;
            EX2_IR: bst_next = tms ? UPD_IR : SH_IR;
            UPD_IR: bst_next = tms ? SEL_DR : RTI;
            default: bst_next = TLR;
        endcase
    endfunction
endpackage

// ---- common/bst_if.sv ----
// Scan link between the external controller and the device test port.
// Assumes the bench resolves the serial output from its enable.
`timescale 1ns/1ps
interface bst_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// ---- rtl/bst_fsm.sv ----
// Sixteen-state test-port controller, advanced on rising test clock.
// Assumes tms is already the pulled-up pin value on the test clock domain.
`timescale 1ns/1ps
module bst_fsm (
    // Clock and reset
    input wire logic tck_i,
    input wire logic resetn_i,
    // Control
    input wire logic tms_i,
    output bst_pkg::bst_state_t state_o
);
    bst_pkg::bst_state_t state_ff;
    always_ff @(posedge tck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= bst_pkg::TLR;
        end else begin
            state_ff <= bst_pkg::bst_next(state_ff, tms_i);
        end
    end
    assign state_o = state_ff;
endmodule

// ---- rtl/bst_ctl.sv ----
// Controller end: drives test clock by divider, shifts instructions and data.
// Assumes one request at a time; valid codes only from the user.
`timescale 1ns/1ps
module bst_ctl #(
    parameter int LEN_W = 7
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Request
    input wire logic start_i,
    input wire logic is_ir_i,
    input wire logic force_reset_i,
    input wire logic [LEN_W-1:0] len_i,
    input wire logic [63:0] data_i,
    output logic busy_o,
    output logic [63:0] data_o,
    // Link
    bst_if.ctl link
);
    typedef enum logic [1:0] {C_IDLE, C_SEQ, C_SHIFT, C_TAIL} bst_cst_t;
    bst_cst_t cst_ff;
    logic [1:0] div_ff;
    logic tck_ff;
    logic tms_ff;
    logic tdi_ff;
    logic [63:0] sh_ff;
    logic [LEN_W-1:0] cnt_ff;
    logic [7:0] seq_ff;
    logic [3:0] seq_n_ff;
    logic fall;
    logic tdo_s1_ff;
    logic tdo_s2_ff;
    logic cap_ff;
    logic [63:0] rx_ff;

    assign fall = tck_ff && (div_ff == 2'(bst_pkg::DIV_HALF - 1));
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_ff <= 2'h0;
            tck_ff <= 1'b0;
        end else if (cst_ff == C_IDLE) begin
            div_ff <= 2'h0;
            tck_ff <= 1'b0;
        end else if (div_ff == 2'(bst_pkg::DIV_HALF - 1)) begin
            div_ff <= 2'h0;
            tck_ff <= ~tck_ff;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_s1_ff <= 1'b0;
            tdo_s2_ff <= 1'b0;
        end else begin
            tdo_s1_ff <= link.tdo;
            tdo_s2_ff <= tdo_s1_ff;
        end
    end

    // A bit put out at one falling edge is read, through the synchroniser, at the next
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_ff <= 1'b0;
            rx_ff <= '0;
        end else if (cst_ff == C_IDLE) begin
            cap_ff <= 1'b0;
            rx_ff <= '0;
        end else if (fall) begin
            cap_ff <= (cst_ff == C_SHIFT);
            if (cap_ff) begin
                rx_ff <= {tdo_s2_ff, rx_ff[63:1]};
            end
        end
    end

    // Sequences change tms on falling tck so the port samples stable values
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cst_ff <= C_IDLE;
            tms_ff <= 1'b1;
            tdi_ff <= 1'b1;
            sh_ff <= '0;
            cnt_ff <= '0;
            seq_ff <= 8'h0;
            seq_n_ff <= 4'h0;
            data_o <= '0;
        end else begin
            case (cst_ff)
                C_IDLE: begin
                    if (start_i) begin
                        sh_ff <= data_i;
                        cnt_ff <= len_i;
                        if (force_reset_i) begin
                            seq_ff <= 8'h3f;
                            seq_n_ff <= 4'(bst_pkg::RESET_TMS_EDGES + 1);
                        end else begin
                            seq_ff <= is_ir_i ? 8'h06 : 8'h02;
                            seq_n_ff <= is_ir_i ? 4'h5 : 4'h4;
                        end
                        cst_ff <= C_SEQ;
                    end
                end
                C_SEQ: if (fall) begin
                    tms_ff <= seq_ff[0];
                    seq_ff <= {1'b0, seq_ff[7:1]};
                    seq_n_ff <= seq_n_ff - 4'h1;
                    if (seq_n_ff == 4'h1) begin
                        cst_ff <= force_reset_i ? C_IDLE : C_SHIFT;
                    end
                end
                C_SHIFT: if (fall) begin
                    tdi_ff <= sh_ff[0];
                    sh_ff <= {1'b0, sh_ff[63:1]};
                    cnt_ff <= cnt_ff - 1'b1;
                    tms_ff <= (cnt_ff == LEN_W'(1));
                    if (cnt_ff == LEN_W'(1)) begin
                        // Third tail bit lets the update state see a rising edge
                        seq_ff <= 8'h01;
                        seq_n_ff <= 4'h3;
                        cst_ff <= C_TAIL;
                    end
                end
                C_TAIL: if (fall) begin
                    tms_ff <= seq_ff[0];
                    seq_ff <= {1'b0, seq_ff[7:1]};
                    seq_n_ff <= seq_n_ff - 4'h1;
                    if (seq_n_ff == 4'h1) begin
                        data_o <= rx_ff;
                        cst_ff <= C_IDLE;
                    end
                end
                default: cst_ff <= C_IDLE;
            endcase
        end
    end

    assign busy_o = (cst_ff != C_IDLE);
    assign link.tck = tck_ff;
    assign link.tms = tms_ff;
    assign link.tdi = tdi_ff;
endmodule

// ---- sim/bst_tap_props.sv ----
// Checker for the scan link between controller end and device end.
// Assumes both ends share resetn_i and the test clock is derived from ref_clk_i.
`timescale 1ns/1ps
module bst_tap_props (
    // Clocks and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic tck,
    // Link
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Five high edges put the controller in reset from any state
    sequence reset_walk;
        tms [* 5];
    endsequence
    sequence to_shift_ir;
        reset_walk ##1 !tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
    endsequence
    sequence to_shift_dr;
        reset_walk ##1 !tms ##1 tms ##1 !tms ##1 !tms;
    endsequence
    tdo_edge_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) tck |-> $stable(tdo))
        else $error("serial output moved while test clock high");
    oe_edge_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) tck |-> $stable(tdo_oe))
        else $error("output enable moved while test clock high");
    port_reset_a: assert property (@(posedge tck) disable iff (!resetn_i) reset_walk |-> !tdo_oe)
        else $error("serial output driven after reset walk");
    ir_capture_a: assert property (@(posedge tck) disable iff (!resetn_i) to_shift_ir |=> tdo_oe && tdo)
        else $error("first instruction bit out is not one");
    ir_pattern_a: assert property (@(posedge tck) disable iff (!resetn_i) to_shift_ir ##1 !tms |=> !tdo)
        else $error("second instruction bit out is not zero");
    id_default_a: assert property (@(posedge tck) disable iff (!resetn_i)
        to_shift_dr |=> tdo_oe && (tdo == bst_pkg::ID_VALUE[0]))
        else $error("identity not selected after reset");
    shift_exit_a: assert property (@(posedge tck) disable iff (!resetn_i) $fell(tdo_oe) |-> $past(tms))
        else $error("shift left without mode select high");
    shift_entry_a: assert property (@(posedge tck) disable iff (!resetn_i) $rose(tdo_oe) |-> !$past(tms))
        else $error("shift entered without mode select low");
    shift_low_c: cover property (@(posedge tck) disable iff (!resetn_i) tdo_oe && !tdi);
endmodule

// ---- sim/boundary_scan_tap_tb.sv ----
// Testbench: controller end and device end joined by one link, user sides driven here.
// Assumes the controller makes the test clock; all requests wait for busy_o to drop.
`timescale 1ns/1ps
module boundary_scan_tap_tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start = 1'b0, is_ir = 1'b0, frc = 1'b0;
    logic [6:0] len = 7'h0;
    logic [63:0] din = 64'h0;
    logic busy;
    logic [63:0] dout;
    logic [39:0] pins = 40'h0;
    logic mem_oe = 1'b1;
    logic [63:0] preload;
    logic extest, q_oe;
    int err_total = 0, tests_run = 0, cyc = 0;
    bst_if link ();
    bst_ctl #(.LEN_W(7)) bst_ctl_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .start_i(start), .is_ir_i(is_ir),
        .force_reset_i(frc), .len_i(len), .data_i(din), .busy_o(busy), .data_o(dout), .link(link));
    bst_tap #(.PIN_W(40)) bst_tap_i (.link(link), .resetn_i(resetn_i), .pins_i(pins), .mem_q_oe_i(mem_oe),
        .preload_o(preload), .extest_o(extest), .q_oe_o(q_oe));
    bst_tap_props bst_tap_props_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .tck(link.tck), .tms(link.tms),
        .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // Generous ceiling: a 64-bit scan costs under 400 reference cycles
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic f, input logic ir, input logic [6:0] n, input logic [63:0] d);
        @(posedge ref_clk_i);
        #1;
        frc = f;
        is_ir = ir;
        len = n;
        din = d;
        start = 1'b1;
        @(posedge ref_clk_i);
        #1;
        start = 1'b0;
        for (int k = 0; k < 4000 && busy !== 1'b0; k++) begin
            @(posedge ref_clk_i);
        end
        #1;
        chk(64'(busy), 64'h0);
    endtask
    task automatic t_reset();
        xfer(1'b1, 1'b0, 7'h0, 64'h0);
        chk(64'(link.tdo_oe), 64'h0);
        chk(64'(preload[47]), 64'h1);
        chk(64'({extest, q_oe}), 64'h1);
    endtask
    task automatic t_idread();
        xfer(1'b0, 1'b0, 7'h20, 64'h0);
        chk(64'(dout[63:32]), 64'(bst_pkg::ID_VALUE));
    endtask
    task automatic t_bypass();
        xfer(1'b1, 1'b0, 7'h0, 64'h0);
        xfer(1'b0, 1'b1, 7'h3, 64'(bst_pkg::OP_BYPASS));
        chk(64'(dout[62:61]), 64'(bst_pkg::IR_CAPTURE_PAT));
        // Bypass adds one stage and captures zero first
        xfer(1'b0, 1'b0, 7'h8, 64'ha5);
        chk(64'(dout[63:56]), 64'h4a);
    endtask
    task automatic t_sample();
        pins = 40'h12_3456_789a;
        xfer(1'b0, 1'b1, 7'h3, 64'(bst_pkg::OP_SAMPLE));
        xfer(1'b0, 1'b0, 7'h40, 64'h5a5a_0000_0000_c3c3);
        chk(64'(dout[39:0]), 64'h12_3456_789a);
        chk(64'(dout[63:48]), 64'h0);
        chk(preload, 64'h5a5a_0000_0000_c3c3);
    endtask
    task automatic t_modes();
        xfer(1'b0, 1'b1, 7'h3, 64'(bst_pkg::OP_EXTEST));
        chk(64'({extest, q_oe}), 64'h2);
        xfer(1'b0, 1'b1, 7'h3, 64'(bst_pkg::OP_SAMPLE_Z));
        chk(64'({extest, q_oe}), 64'h0);
        xfer(1'b0, 1'b1, 7'h3, 64'(bst_pkg::OP_IDREAD));
        chk(64'({extest, q_oe}), 64'h1);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        t_reset();
        t_idread();
        t_bypass();
        t_sample();
        t_modes();
        tally_and_finish();
    end
endmodule
